// file: include/rmw_pkg.sv
// constants and types shared by the reset manager with watchdog
`default_nettype none
package rmw_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map
	localparam int         ADDR_W     = 2;
	localparam int         DATA_W     = 8;
	localparam logic [1:0] ADDR_CAUSE = 2'h0;
	localparam logic [1:0] ADDR_CTRL  = 2'h1;
	localparam logic [1:0] ADDR_WDOG  = 2'h2;

	// field positions
	localparam int SLEEP_BIT = 7;
	localparam int CAUSE_LSB = 1;
	localparam int CTRL_LSB  = 4;

	// reset values
	localparam logic [3:0] CTRL_RST  = 4'h0;
	localparam logic [4:0] CAUSE_RST = 5'h00;
	localparam logic [3:0] WD_RST    = 4'h0;

	// watchdog key sequence and limit
	localparam logic [7:0] KEY_FIRST  = 8'h0A;
	localparam logic [7:0] KEY_SECOND = 8'h03;
	localparam logic [3:0] WD_LIMIT   = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_MHZ          = 200;
	localparam int CLK_KHZ          = 200000;
	localparam int POR_MIN_MS       = 5;
	localparam int POR_MAX_MS       = 20;
	localparam int PIN_OLD_MIN_US   = 20;
	localparam int PIN_OLD_MAX_US   = 200;
	localparam int PIN_NEW_MIN_MS   = 5;
	localparam int PIN_NEW_MAX_MS   = 20;
	localparam int POR_CYC          = POR_MIN_MS * CLK_KHZ;
	localparam int PIN_OLD_HOLD_CYC = PIN_OLD_MIN_US * CLK_MHZ;
	localparam int PIN_NEW_HOLD_CYC = PIN_NEW_MIN_MS * CLK_KHZ;
	localparam int EVT_HOLD_CYC     = 4;
	localparam int CNT_W            = 21;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic sleep_unlock;
		logic port_config_reset_enable;
		logic bad_access_reset_enable;
		logic watchdog_reset_enable;
	} rmw_ctrl_t;

	typedef struct packed {
		logic flag_bad_access;
		logic flag_watchdog;
		logic flag_port_combination;
		logic flag_reset_pin;
		logic flag_reset_pin_asleep;
	} rmw_cause_t;

	typedef struct packed {
		logic cold;
		logic system;
		logic pconf;
		logic sleep;
	} rmw_resets_t;

endpackage
`default_nettype wire

// file: logic/rmw_reset_manager.sv
// reset manager: reset merging, cause flags, sleep entry and key-cleared watchdog
// Operation
// [RQ1] supply rise asserts reset; release waits for regulator start-up, no voltage check.
// [RQ2] high level on external reset pin activates reset.
// [RQ3] port A combination request is accepted as a reset source.
// [RQ4] enabled watchdog that expires uncleared generates a reset.
// [RQ5] enabled bad-access detection generates reset on unmapped address access.
// [RQ6] sleep request with unlock set enters sleep; sleep reset held throughout.
// [RQ7] sleep request has no effect while unlock bit is zero.
// [RQ8] sleep request bit always reads zero.
// [RQ9] cause register holds one flag per source, set by that source.
// [RQ10] pin waking from sleep sets both pin and pin-asleep flags.
// [RQ11] power-on reset leaves all cause flags zero.
// [RQ12] flags accumulate until any write to cause register clears all.
// [RQ13] watchdog enable, once set, is cleared only by power-on reset.
// [RQ14] port configuration reset follows other sources only when enabled.
// [RQ15] watchdog cleared only by key 0x0A then 0x03 in consecutive writes.
// [RQ16] any other watchdog write between the keys voids the sequence.
// [RQ17] 4-bit watchdog counter counts 0 to 7, readable, fires at 8.
// [RQ18] software must clear watchdog at least every 2 seconds.
// [RQ19] power-on reset held between 5 and 20 ms before execution.
// [RQ20] reset held after pin falling edge for the revision's hold time.
// [RQ21] watchdog ticks from low prescaler; stops on external clock without RC.
// [RQ22] cold reset only on power-on; system reset on cold or enabled source.
// [RQ23] watchdog counter zeroes on cold reset and valid key pair, then ticks.
`default_nettype none
`timescale 1ns/1ps
module rmw_reset_manager #(
	parameter int POR_CYC      = rmw_pkg::POR_CYC,
	parameter int PIN_HOLD_CYC = rmw_pkg::PIN_NEW_HOLD_CYC,
	parameter int EVT_HOLD_CYC = rmw_pkg::EVT_HOLD_CYC
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_nrst,
	input  wire logic                        i_supply_up,
	input  wire logic                        i_vreg_ready,
	input  wire logic                        i_reset_pin,
	input  wire logic                        i_porta_req,
	input  wire logic                        i_bad_access,
	input  wire logic                        i_lowpre_tick,
	input  wire logic                        i_rc_oscillator_enable,
	input  wire logic                        i_ext_clk_sel,
	input  wire logic [rmw_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [rmw_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [rmw_pkg::DATA_W-1:0]  o_rdata,
	output rmw_pkg::rmw_resets_t             o_resets,
	output logic                             o_asleep
);

	localparam int CW = rmw_pkg::CNT_W;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic supply_m_r;
	logic supply_s_r;
	logic pin_m_r;
	logic pin_s_r;
	logic pin_d_r;

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			supply_m_r <= 1'b0;
			supply_s_r <= 1'b0;
			pin_m_r    <= 1'b0;
			pin_s_r    <= 1'b0;
			pin_d_r    <= 1'b0;
		end
		else
		begin
			supply_m_r <= i_supply_up;
			supply_s_r <= supply_m_r;
			pin_m_r    <= i_reset_pin;
			pin_s_r    <= pin_m_r;
			pin_d_r    <= pin_s_r;
		end
	end

	logic pin_rise;
	assign pin_rise = pin_s_r && !pin_d_r;

	////////////////////////////////////////////////////////////////////////////////
	// power-on detector
	logic [CW-1:0] por_cnt_r;
	logic          cold_r;
	logic          por_run;
	logic          por_done;

	assign por_run  = supply_s_r && i_vreg_ready;
	assign por_done = (por_cnt_r == CW'(POR_CYC));

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			por_cnt_r <= '0;
			cold_r    <= 1'b1;
		end
		else
		begin
			if (!por_run)
				por_cnt_r <= '0; // [RQ1]
			else if (!por_done)
				por_cnt_r <= por_cnt_r + CW'(1); // [RQ19]
			cold_r <= !(por_run && por_done); // [RQ1] [RQ22]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset pin hold after the falling edge
	logic [CW-1:0] pin_cnt_r;
	logic          pin_busy;

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			pin_cnt_r <= '0;
		else if (pin_s_r)
			pin_cnt_r <= CW'(PIN_HOLD_CYC); // [RQ20]
		else if (pin_cnt_r != '0)
			pin_cnt_r <= pin_cnt_r - CW'(1);
	end

	assign pin_busy = pin_s_r || (pin_cnt_r != '0); // [RQ2] [RQ20]

	////////////////////////////////////////////////////////////////////////////////
	// control register
	rmw_pkg::rmw_ctrl_t ctrl_r;
	logic               wr_cause;
	logic               wr_ctrl;
	logic               wr_wdog;

	assign wr_cause = i_wr && (i_addr == rmw_pkg::ADDR_CAUSE);
	assign wr_ctrl  = i_wr && (i_addr == rmw_pkg::ADDR_CTRL);
	assign wr_wdog  = i_wr && (i_addr == rmw_pkg::ADDR_WDOG);

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			ctrl_r <= rmw_pkg::CTRL_RST;
		else if (cold_r)
			ctrl_r <= rmw_pkg::CTRL_RST; // [RQ13]
		else if (wr_ctrl)
		begin
			ctrl_r.sleep_unlock             <= i_wdata[rmw_pkg::CTRL_LSB+3];
			ctrl_r.port_config_reset_enable <= i_wdata[rmw_pkg::CTRL_LSB+2];
			ctrl_r.bad_access_reset_enable  <= i_wdata[rmw_pkg::CTRL_LSB+1];
			ctrl_r.watchdog_reset_enable    <= ctrl_r.watchdog_reset_enable
				| i_wdata[rmw_pkg::CTRL_LSB]; // [RQ13]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// watchdog key sequence and counter
	logic       key_armed_r;
	logic [3:0] wd_cnt_r;
	logic       wd_tick;
	logic       wd_clear;
	logic       wd_fire;

	assign wd_tick  = i_lowpre_tick && (i_rc_oscillator_enable || !i_ext_clk_sel); // [RQ21]
	assign wd_clear = wr_wdog && key_armed_r && (i_wdata == rmw_pkg::KEY_SECOND); // [RQ15]
	assign wd_fire  = (wd_cnt_r == rmw_pkg::WD_LIMIT); // [RQ17]

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			key_armed_r <= 1'b0;
		else if (cold_r)
			key_armed_r <= 1'b0;
		else if (wr_wdog)
			key_armed_r <= (i_wdata == rmw_pkg::KEY_FIRST); // [RQ15] [RQ16]
	end

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			wd_cnt_r <= rmw_pkg::WD_RST;
		else if (cold_r || wd_clear || wd_fire)
			wd_cnt_r <= rmw_pkg::WD_RST; // [RQ23]
		else if (wd_tick)
			wd_cnt_r <= wd_cnt_r + 4'h1; // [RQ17] [RQ23]
	end

	////////////////////////////////////////////////////////////////////////////////
	// event-source reset stretch
	logic [CW-1:0] evt_cnt_r;
	logic          wd_hit;
	logic          bad_hit;
	logic          evt_busy;

	assign wd_hit   = wd_fire && ctrl_r.watchdog_reset_enable; // [RQ4]
	assign bad_hit  = i_bad_access && ctrl_r.bad_access_reset_enable; // [RQ5]
	assign evt_busy = (evt_cnt_r != '0);

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			evt_cnt_r <= '0;
		else if (wd_hit || bad_hit)
			evt_cnt_r <= CW'(EVT_HOLD_CYC); // [RQ4] [RQ5]
		else if (evt_busy)
			evt_cnt_r <= evt_cnt_r - CW'(1);
	end

	////////////////////////////////////////////////////////////////////////////////
	// internal reset outputs
	logic sys_r;
	logic pconf_r;
	logic sys_src;

	assign sys_src = cold_r || pin_busy || i_porta_req || evt_busy; // [RQ22] [RQ3]

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sys_r   <= 1'b1;
			pconf_r <= 1'b1;
		end
		else
		begin
			sys_r   <= sys_src; // [RQ22]
			pconf_r <= cold_r || pin_busy
				|| (ctrl_r.port_config_reset_enable && (i_porta_req || evt_busy)); // [RQ14]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sleep control
	logic asleep_r;
	logic sleep_go;

	assign sleep_go = wr_cause && i_wdata[rmw_pkg::SLEEP_BIT] && ctrl_r.sleep_unlock; // [RQ6] [RQ7]

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			asleep_r <= 1'b0;
		else if (sys_r)
			asleep_r <= 1'b0;
		else if (sleep_go)
			asleep_r <= 1'b1; // [RQ6]
	end

	assign o_resets.cold   = cold_r;
	assign o_resets.system = sys_r;
	assign o_resets.pconf  = pconf_r;
	assign o_resets.sleep  = asleep_r || cold_r; // [RQ6]
	assign o_asleep        = asleep_r;

	////////////////////////////////////////////////////////////////////////////////
	// reset cause flags
	rmw_pkg::rmw_cause_t cause_r;
	rmw_pkg::rmw_cause_t cause_set;

	always_comb
	begin
		cause_set.flag_bad_access       = bad_hit;
		cause_set.flag_watchdog         = wd_hit;
		cause_set.flag_port_combination = i_porta_req;
		cause_set.flag_reset_pin        = pin_rise;
		cause_set.flag_reset_pin_asleep = pin_rise && asleep_r; // [RQ10]
	end

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			cause_r <= rmw_pkg::CAUSE_RST;
		else if (cold_r)
			cause_r <= rmw_pkg::CAUSE_RST; // [RQ11]
		else if (wr_cause)
			cause_r <= cause_set; // [RQ12]
		else
			cause_r <= cause_r | cause_set; // [RQ9] [RQ12]
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= 8'h00;
		else if (i_rd)
		begin
			unique case (i_addr)
				rmw_pkg::ADDR_CAUSE: o_rdata <= {2'b00, cause_r, 1'b0}; // [RQ8] [RQ9]
				rmw_pkg::ADDR_CTRL:  o_rdata <= {ctrl_r, 4'h0};
				rmw_pkg::ADDR_WDOG:  o_rdata <= {4'h0, wd_cnt_r}; // [RQ17]
				default:             o_rdata <= 8'h00;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);

	property p_por_hold;
		!supply_s_r |=> o_resets.cold ##1 (o_resets.system && o_resets.pconf);
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("cold reset not held on supply low"); // [RQ1]

	property p_pin_reset;
		pin_s_r |=> o_resets.system && o_resets.pconf;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not reset"); // [RQ2]

	property p_porta_reset;
		i_porta_req |=> o_resets.system ##0 cause_r.flag_port_combination;
	endproperty
	a_porta_reset: assert property (p_porta_reset) else $error("port A request ignored"); // [RQ3]

	property p_wd_reset;
		wd_fire && ctrl_r.watchdog_reset_enable |-> ##2 o_resets.system[*4];
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("watchdog expiry did not reset"); // [RQ4]

	property p_bad_reset;
		bad_hit |-> ##2 o_resets.system;
	endproperty
	a_bad_reset: assert property (p_bad_reset) else $error("bad access did not reset"); // [RQ5]

	property p_sleep_enter;
		sleep_go && !sys_r |=> o_asleep && o_resets.sleep;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered"); // [RQ6]

	property p_sleep_locked;
		wr_cause && !ctrl_r.sleep_unlock && !o_asleep |=> !o_asleep;
	endproperty
	a_sleep_locked: assert property (p_sleep_locked) else $error("locked sleep entered"); // [RQ7]

	property p_sleep_reads_zero;
		i_rd && (i_addr == rmw_pkg::ADDR_CAUSE) |=> !o_rdata[rmw_pkg::SLEEP_BIT];
	endproperty
	a_sleep_reads_zero: assert property (p_sleep_reads_zero) else $error("sleep bit read one"); // [RQ8]

	property p_cause_clear;
		wr_cause && !cold_r && (cause_set == '0) |=> (cause_r == '0);
	endproperty
	a_cause_clear: assert property (p_cause_clear) else $error("cause write did not clear"); // [RQ12]

	property p_wd_sticky;
		ctrl_r.watchdog_reset_enable && !cold_r |=> ctrl_r.watchdog_reset_enable;
	endproperty
	a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog enable dropped"); // [RQ13]

	property p_key_clear;
		wd_clear && !cold_r |=> (wd_cnt_r == rmw_pkg::WD_RST);
	endproperty
	a_key_clear: assert property (p_key_clear) else $error("key pair did not clear watchdog"); // [RQ15]

	property p_key_void;
		wr_wdog && (i_wdata != rmw_pkg::KEY_FIRST) |=> !key_armed_r;
	endproperty
	a_key_void: assert property (p_key_void) else $error("key sequence not voided"); // [RQ16]

	property p_wd_range;
		wd_cnt_r <= rmw_pkg::WD_LIMIT;
	endproperty
	a_wd_range: assert property (p_wd_range) else $error("watchdog counter out of range"); // [RQ17]

	c_sleep_entry: cover property (sleep_go ##1 o_asleep);
	c_pin_wake:    cover property (o_asleep && pin_rise ##1 cause_r.flag_reset_pin_asleep);
	c_wd_cleared:  cover property (wr_wdog && i_wdata == rmw_pkg::KEY_FIRST ##[1:2] wd_clear);
	c_wd_expire:   cover property (wd_hit ##2 o_resets.system);

endmodule // rmw_reset_manager
`default_nettype wire

// file: sim/rmw_far_model.sv
// far-side model: reset pin, port A combination, bus error and prescaler tick
`timescale 1ns/1ps
`default_nettype none
module rmw_far_model (
	input  wire logic i_mclk,
	input  wire logic i_nrst,
	input  wire logic i_pin_cmd,
	input  wire logic i_porta_cmd,
	input  wire logic i_bad_cmd,
	input  wire logic i_tick_cmd,
	output logic      o_reset_pin,
	output logic      o_porta_req,
	output logic      o_bad_access,
	output logic      o_lowpre_tick
);
	// bad access and tick give one-cycle pulses, every other cycle while the command stays up; pin and port A follow their commands
	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_reset_pin   <= 1'b0;
			o_porta_req   <= 1'b0;
			o_bad_access  <= 1'b0;
			o_lowpre_tick <= 1'b0;
		end
		else
		begin
			o_reset_pin   <= i_pin_cmd;
			o_porta_req   <= i_porta_cmd;
			o_bad_access  <= i_bad_cmd & ~o_bad_access;
			o_lowpre_tick <= i_tick_cmd & ~o_lowpre_tick;
		end
	end
endmodule // rmw_far_model
`default_nettype wire

// file: sim/rmw_reset_manager_tb.sv
// self-checking bench for the reset manager with watchdog
`timescale 1ns/1ps
`default_nettype none
module rmw_reset_manager_tb;
	localparam int POR_N = 20;
	localparam int PIN_N = 10;
	typedef struct packed {
		logic       wr;
		logic [1:0] addr;
		logic [7:0] data;
		logic [7:0] exp;
	} rmw_row_t;
	logic                 mclk       = 1'b0;
	logic                 nrst       = 1'b0;
	logic                 vreg       = 1'b0;
	logic                 supply     = 1'b1;
	logic                 rc_en      = 1'b1;
	logic                 ext_sel    = 1'b0;
	logic [1:0]           addr       = 2'h0;
	logic [7:0]           wdata      = 8'h00;
	logic                 wr         = 1'b0;
	logic                 rd         = 1'b0;
	logic                 pin_cmd    = 1'b0;
	logic                 porta_cmd  = 1'b0;
	logic                 bad_cmd    = 1'b0;
	logic                 tick_cmd   = 1'b0;
	logic                 pconf_seen = 1'b0;
	logic                 sys_seen   = 1'b0;
	logic                 cold_bad   = 1'b0;
	logic                 por_done   = 1'b0;
	logic                 pin;
	logic                 porta;
	logic                 bad;
	logic                 tick;
	logic [7:0]           rdata;
	logic                 asleep;
	rmw_pkg::rmw_resets_t rst;
	int                   failures   = 0;
	int                   n_checks   = 0;
	rmw_row_t             rows [10]  = '{
		'{1'b0, rmw_pkg::ADDR_CAUSE, 8'h00, 8'h00},
		'{1'b0, rmw_pkg::ADDR_CTRL, 8'h00, 8'h00},
		'{1'b1, rmw_pkg::ADDR_CTRL, 8'h1F, 8'h00},
		'{1'b0, rmw_pkg::ADDR_CTRL, 8'h00, 8'h10},
		'{1'b1, rmw_pkg::ADDR_CTRL, 8'h00, 8'h00},
		'{1'b0, rmw_pkg::ADDR_CTRL, 8'h00, 8'h10},
		'{1'b0, rmw_pkg::ADDR_WDOG, 8'h00, 8'h00},
		'{1'b0, 2'h3, 8'h00, 8'h00},
		'{1'b1, rmw_pkg::ADDR_CAUSE, 8'h80, 8'h00},
		'{1'b0, rmw_pkg::ADDR_CAUSE, 8'h00, 8'h00}
	};

	always #2.5 mclk = ~mclk;

	rmw_far_model i_far (.i_mclk(mclk), .i_nrst(nrst), .i_pin_cmd(pin_cmd),
		.i_porta_cmd(porta_cmd), .i_bad_cmd(bad_cmd), .i_tick_cmd(tick_cmd),
		.o_reset_pin(pin), .o_porta_req(porta), .o_bad_access(bad), .o_lowpre_tick(tick));

	rmw_reset_manager #(.POR_CYC(POR_N), .PIN_HOLD_CYC(PIN_N),
		.EVT_HOLD_CYC(rmw_pkg::EVT_HOLD_CYC)) i_dut (
		.i_mclk(mclk), .i_nrst(nrst), .i_supply_up(supply), .i_vreg_ready(vreg),
		.i_reset_pin(pin), .i_porta_req(porta), .i_bad_access(bad), .i_lowpre_tick(tick),
		.i_rc_oscillator_enable(rc_en), .i_ext_clk_sel(ext_sel), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_resets(rst),
		.o_asleep(asleep));

	// sticky observations of the reset outputs, taken once the edge has settled
	always @(posedge mclk)
	begin
		#1;
		if (rst.pconf === 1'b1)
			pconf_seen = 1'b1;
		if (rst.system === 1'b1)
			sys_seen = 1'b1;
		if (por_done && rst.cold !== 1'b0)
			cold_bad = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge mclk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk("read data", exp, rdata);
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			tick_cmd <= 1'b1;
			@(posedge mclk);
			tick_cmd <= 1'b0;
		end
	endtask

	task automatic pulse_bad();
		@(posedge mclk);
		bad_cmd <= 1'b1;
		@(posedge mclk);
		bad_cmd <= 1'b0;
	endtask

	task automatic wait_sys(input logic want, input int lim, output int cnt);
		cnt = 0;
		while (rst.system !== want && cnt < lim)
		begin
			@(posedge mclk);
			#1;
			cnt++;
		end
		if (cnt >= lim)
		begin
			failures++;
			$display("unexpected system reset: expected %b, seen %b", want, rst.system);
			wrap_up();
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge mclk);
		failures++;
		wrap_up();
	end

	initial
	begin
		int c;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (30) @(posedge mclk);
		#1;
		chk("cold before regulator", 8'h01, {7'h0, rst.cold});
		chk("system during cold", 8'h01, {7'h0, rst.system});
		@(posedge mclk);
		vreg <= 1'b1;
		c = 0;
		while (rst.cold !== 1'b0 && c < 200)
		begin
			@(posedge mclk);
			#1;
			c++;
		end
		chk("power-on hold", 8'h01, {7'h0, c >= POR_N && c <= POR_N + 8});
		wait_sys(1'b0, 8, c);
		por_done = 1'b1;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr_reg(rows[i].addr, rows[i].data);
			else
				rd_chk(rows[i].addr, rows[i].exp);
		end
		chk("asleep when locked", 8'h00, {7'h0, asleep});
		ticks(5);
		rd_chk(rmw_pkg::ADDR_WDOG, 8'h05);
		wr_reg(rmw_pkg::ADDR_WDOG, rmw_pkg::KEY_FIRST);
		wr_reg(rmw_pkg::ADDR_WDOG, 8'h55);
		wr_reg(rmw_pkg::ADDR_WDOG, rmw_pkg::KEY_SECOND);
		rd_chk(rmw_pkg::ADDR_WDOG, 8'h05);
		wr_reg(rmw_pkg::ADDR_WDOG, rmw_pkg::KEY_FIRST);
		wr_reg(rmw_pkg::ADDR_WDOG, rmw_pkg::KEY_SECOND);
		rd_chk(rmw_pkg::ADDR_WDOG, 8'h00);
		@(posedge mclk);
		rc_en   <= 1'b0;
		ext_sel <= 1'b1;
		ticks(3);
		rd_chk(rmw_pkg::ADDR_WDOG, 8'h00);
		@(posedge mclk);
		// external clock stays selected: an enabled rc oscillator keeps the watchdog ticking
		rc_en   <= 1'b1;
		wr_reg(rmw_pkg::ADDR_CTRL, 8'h50);
		pconf_seen = 1'b0;
		ticks(7);
		rd_chk(rmw_pkg::ADDR_WDOG, 8'h07);
		ticks(1);
		wait_sys(1'b1, 8, c);
		wait_sys(1'b0, 12, c);
		chk("pconf on watchdog", 8'h01, {7'h0, pconf_seen});
		rd_chk(rmw_pkg::ADDR_WDOG, 8'h00);
		rd_chk(rmw_pkg::ADDR_CAUSE, 8'h10);
		wr_reg(rmw_pkg::ADDR_CAUSE, 8'h00);
		rd_chk(rmw_pkg::ADDR_CAUSE, 8'h00);
		sys_seen = 1'b0;
		pulse_bad();
		repeat (8) @(posedge mclk);
		#1;
		chk("bad access disabled", 8'h00, {7'h0, sys_seen});
		wr_reg(rmw_pkg::ADDR_CTRL, 8'h70);
		pconf_seen = 1'b0;
		pulse_bad();
		wait_sys(1'b1, 8, c);
		wait_sys(1'b0, 12, c);
		chk("pconf on bad access", 8'h01, {7'h0, pconf_seen});
		wr_reg(rmw_pkg::ADDR_CTRL, 8'h30);
		pconf_seen = 1'b0;
		@(posedge mclk);
		porta_cmd <= 1'b1;
		wait_sys(1'b1, 6, c);
		@(posedge mclk);
		porta_cmd <= 1'b0;
		wait_sys(1'b0, 10, c);
		chk("pconf kept", 8'h00, {7'h0, pconf_seen});
		rd_chk(rmw_pkg::ADDR_CAUSE, 8'h28);
		wr_reg(rmw_pkg::ADDR_CAUSE, 8'hFF);
		rd_chk(rmw_pkg::ADDR_CAUSE, 8'h00);
		wr_reg(rmw_pkg::ADDR_CTRL, 8'hB0);
		wr_reg(rmw_pkg::ADDR_CAUSE, 8'h80);
		#1;
		chk("asleep", 8'h01, {7'h0, asleep});
		repeat (5) @(posedge mclk);
		#1;
		chk("sleep reset", 8'h01, {7'h0, rst.sleep});
		@(posedge mclk);
		pin_cmd <= 1'b1;
		wait_sys(1'b1, 8, c);
		repeat (3) @(posedge mclk);
		pin_cmd <= 1'b0;
		#1;
		chk("awake after pin", 8'h00, {7'h0, asleep});
		wait_sys(1'b0, PIN_N + 20, c);
		chk("pin hold", 8'h01, {7'h0, c >= PIN_N && c <= PIN_N + 8});
		rd_chk(rmw_pkg::ADDR_CAUSE, 8'h06);
		// supply drop mid-run: power-on clears the flags and the sticky watchdog enable
		por_done = 1'b0;
		@(posedge mclk);
		supply <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk("cold on supply drop", 8'h01, {7'h0, rst.cold});
		chk("system on supply drop", 8'h01, {7'h0, rst.system});
		@(posedge mclk);
		supply <= 1'b1;
		repeat (POR_N + 8) @(posedge mclk);
		#1;
		chk("cold after supply rise", 8'h00, {7'h0, rst.cold});
		wait_sys(1'b0, 8, c);
		por_done = 1'b1;
		rd_chk(rmw_pkg::ADDR_CAUSE, 8'h00);
		rd_chk(rmw_pkg::ADDR_CTRL, 8'h00);
		chk("cold after power-on", 8'h00, {7'h0, cold_bad});
		wrap_up();
	end
endmodule // rmw_reset_manager_tb
`default_nettype wire
